// >>> rtl/phase_energy_pkg.sv
// Constants, register map and carrier types for the per-phase energy accumulators
// How it works
// - Positive per-cycle fundamental reactive energy adds into the positive reactive total.
// - Positive reactive total wrapping past 32 bits sets its phase overflow flag.
// - Negative per-cycle fundamental reactive energy adds its magnitude to the negative total.
// - Negative reactive total wrapping past 32 bits sets its phase overflow flag.
// - Per-cycle fundamental apparent energy adds to the apparent total, sign untested.
// - Apparent total wrapping past 32 bits sets its phase overflow flag.
// - In low-power mode no energy enters any energy total.
// - In low-power mode current enters the apparent total, counting ampere-hours.
// - Each sample period adds instantaneous voltage times current to a running sum.
// - At cycle end the running sum is copied to the signed per-cycle real register.
// - The per-cycle real result adds by sign into positive or negative real totals.
// - One energy LSB weighs full-scale voltage times current times cycle over 2^16.
// - Flag register: apparent bit 4, negative reactive bit 3, positive reactive bit 2.
// - Flags stay set until the host clears them; host corrects differences by 2^32.
// - Per-cycle fundamental reactive input is signed, fundamental-frequency only.
package phase_energy_pkg;

  localparam int NUM_PHASES = 3;
  localparam int ENERGY_W = 32;
  localparam int SAMPLE_W = 16;
  localparam int ADDR_W = 12;
  localparam int FLAG_W = 8;

  // Energy LSB is full scale V times full scale I times cycle time, shifted down by this
  localparam int ENERGY_LSB_SHIFT = 16;

  // Overflow flag bit positions, bits 7:5 read as zero
  localparam int FLAG_APPARENT_BIT = 4;
  localparam int FLAG_REACT_NEG_BIT = 3;
  localparam int FLAG_REACT_POS_BIT = 2;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 8'h00;
  localparam logic [ENERGY_W-1:0] ENERGY_RESET = 32'h00000000;

  // Register offsets per phase A, B, C
  localparam logic [ADDR_W-1:0] ADDR_REAL_CYCLE [NUM_PHASES] = '{12'h1D0, 12'h2BC, 12'h3A8};
  localparam logic [ADDR_W-1:0] ADDR_REACT_POS [NUM_PHASES] = '{12'h204, 12'h2F0, 12'h3DC};
  localparam logic [ADDR_W-1:0] ADDR_REACT_NEG [NUM_PHASES] = '{12'h208, 12'h2F4, 12'h3E0};
  localparam logic [ADDR_W-1:0] ADDR_APPARENT [NUM_PHASES] = '{12'h20C, 12'h2F8, 12'h3E4};
  localparam logic [ADDR_W-1:0] ADDR_FLAGS [NUM_PHASES] = '{12'h147, 12'h233, 12'h31F};
  localparam logic [ADDR_W-1:0] ADDR_REAL_POS [NUM_PHASES] = '{12'h210, 12'h2FC, 12'h3E8};
  localparam logic [ADDR_W-1:0] ADDR_REAL_NEG [NUM_PHASES] = '{12'h214, 12'h300, 12'h3EC};

  // Accumulator slots inside one phase
  typedef enum {
    SLOT_REACT_POS,
    SLOT_REACT_NEG,
    SLOT_APPARENT,
    SLOT_REAL_POS,
    SLOT_REAL_NEG,
    SLOT_COUNT
  } slot_e;

  // Front-end values delivered for one phase
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] inst_voltage;
    logic signed [SAMPLE_W-1:0] inst_current;
    logic signed [ENERGY_W-1:0] fund_reactive_last_cycle;
    logic [ENERGY_W-1:0] fund_apparent_last_cycle;
    logic [ENERGY_W-1:0] current_last_cycle;
  } phase_in_s;

  // Host register access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [FLAG_W-1:0] wdata;
  } reg_req_s;

endpackage

// >>> rtl/energy_accum.sv
// Wrapping unsigned energy accumulator with a carry-out pulse
`timescale 1ns/1ns
`default_nettype none
module energy_accum #(
  parameter int WIDTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic add_en,
  input wire logic [WIDTH-1:0] addend,
  output logic [WIDTH-1:0] total,
  output logic wrap_pulse
);

  logic [WIDTH:0] sum;

  if (WIDTH < 2) begin : g_bad_width
    $error("energy_accum needs WIDTH of at least 2");
  end

  // Carry bit out of the top tells the flag logic the total wrapped
  assign sum = {1'b0, total} + {1'b0, addend};

  // Wraps modulo 2^WIDTH instead of saturating so the host can unwrap with one flag
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      total <= '0;
      wrap_pulse <= 1'b0;
    end else begin
      wrap_pulse <= add_en & sum[WIDTH];
      if (add_en) begin
        total <= sum[WIDTH-1:0];
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/real_power_sum.sv
// Running sum of instantaneous power over one DSP cycle
`timescale 1ns/1ns
`default_nettype none
module real_power_sum #(
  parameter int SAMPLE_W = 16,
  parameter int ENERGY_W = 32
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sample_en,
  input wire logic cycle_end,
  input wire logic signed [SAMPLE_W-1:0] inst_voltage,
  input wire logic signed [SAMPLE_W-1:0] inst_current,
  output logic signed [ENERGY_W-1:0] last_cycle,
  output logic done_pulse
);

  logic signed [ENERGY_W-1:0] run_reg;
  logic signed [ENERGY_W-1:0] run_next;
  logic signed [2*SAMPLE_W-1:0] product;

  if (2 * SAMPLE_W > ENERGY_W) begin : g_bad_width
    $error("real_power_sum needs ENERGY_W of at least twice SAMPLE_W");
  end

  assign product = inst_voltage * inst_current;

  // A sample landing on the cycle end still belongs to the closing cycle
  always_comb begin
    run_next = run_reg;
    if (sample_en) begin
      run_next = run_reg + ENERGY_W'(product);
    end
  end

  // Copy out and restart at the boundary
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run_reg <= '0;
      last_cycle <= '0;
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= cycle_end;
      if (cycle_end) begin
        last_cycle <= run_next;
        run_reg <= '0;
      end else begin
        run_reg <= run_next;
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/phase_energy_accumulators.sv
// Three-phase fundamental and real energy accumulators with host register read-out
`timescale 1ns/1ns
`default_nettype none
module phase_energy_accumulators (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sample_en,
  input wire logic cycle_end,
  input wire logic low_power,
  input wire phase_energy_pkg::phase_in_s phase_in [phase_energy_pkg::NUM_PHASES],
  input wire phase_energy_pkg::reg_req_s reg_req,
  output logic [phase_energy_pkg::ENERGY_W-1:0] reg_rdata,
  output logic reg_rvalid
);

  localparam int NP = phase_energy_pkg::NUM_PHASES;
  localparam int EW = phase_energy_pkg::ENERGY_W;
  localparam int FW = phase_energy_pkg::FLAG_W;
  localparam int NS = int'(phase_energy_pkg::SLOT_COUNT);
  // Registers per phase: the five totals, the last-cycle real word and the flag byte
  localparam int NR = NS + 2;
  localparam int AW = phase_energy_pkg::ADDR_W;
  localparam int BIT_APP = phase_energy_pkg::FLAG_APPARENT_BIT;
  localparam int BIT_RNEG = phase_energy_pkg::FLAG_REACT_NEG_BIT;
  localparam int BIT_RPOS = phase_energy_pkg::FLAG_REACT_POS_BIT;

  logic [EW-1:0] total [NP][NS];
  logic wrap [NP][NS];
  logic add_en [NP][NS];
  logic [EW-1:0] addend [NP][NS];
  logic signed [EW-1:0] real_cycle [NP];
  logic real_done [NP];
  logic [FW-1:0] flags_reg [NP];
  logic [EW-1:0] rdata_next;

  // Flags share the read word with the totals, so the byte must fit inside it
  if (EW < 2 || FW > EW) begin : g_bad_width
    $error("phase_energy_accumulators needs ENERGY_W of at least FLAG_W and 2");
  end

  // Each overflow flag needs its own bit inside the flag byte
  if (BIT_APP >= FW || BIT_RNEG >= FW || BIT_RPOS >= FW) begin : g_bad_flag_range
    $error("an overflow flag bit lies outside the flag byte");
  end
  if (BIT_APP == BIT_RNEG || BIT_APP == BIT_RPOS || BIT_RNEG == BIT_RPOS) begin : g_flag_clash
    $error("two overflow flags share one bit");
  end

  // Offset of register r of phase p; order follows the read decode below
  function automatic logic [AW-1:0] reg_offset(input int p, input int r);
    logic [AW-1:0] off;
    off = phase_energy_pkg::ADDR_FLAGS[p];
    if (r == 0) begin
      off = phase_energy_pkg::ADDR_REAL_CYCLE[p];
    end else if (r == 1) begin
      off = phase_energy_pkg::ADDR_REACT_POS[p];
    end else if (r == 2) begin
      off = phase_energy_pkg::ADDR_REACT_NEG[p];
    end else if (r == 3) begin
      off = phase_energy_pkg::ADDR_APPARENT[p];
    end else if (r == 4) begin
      off = phase_energy_pkg::ADDR_REAL_POS[p];
    end else if (r == 5) begin
      off = phase_energy_pkg::ADDR_REAL_NEG[p];
    end
    return off;
  endfunction

  // The read decode is a priority chain, so two registers on one offset would hide one
  for (genvar i = 0; i < NP * NR; i++) begin : g_map_a
    for (genvar j = i + 1; j < NP * NR; j++) begin : g_map_b
      if (reg_offset(i / NR, i % NR) == reg_offset(j / NR, j % NR)) begin : g_clash
        $error("two registers share one read offset");
      end
    end
  end

  for (genvar p = 0; p < NP; p++) begin : g_phase
    logic signed [EW-1:0] react;
    logic [FW-1:0] flag_set;
    logic [FW-1:0] flag_clr;

    // Input is signed and already restricted to the fundamental
    assign react = phase_in[p].fund_reactive_last_cycle;

    // Each phase owns the same, independent set of accumulators
    real_power_sum #(
      .SAMPLE_W(phase_energy_pkg::SAMPLE_W),
      .ENERGY_W(EW)
    ) u_real (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .sample_en(sample_en),
      .cycle_end(cycle_end),
      .inst_voltage(phase_in[p].inst_voltage),
      .inst_current(phase_in[p].inst_current),
      .last_cycle(real_cycle[p]),
      .done_pulse(real_done[p])
    );

    // Reactive energy is steered by sign; zero goes nowhere
    always_comb begin
      add_en[p][phase_energy_pkg::SLOT_REACT_POS] =
        cycle_end & ~low_power & (react > 0);
      addend[p][phase_energy_pkg::SLOT_REACT_POS] = react;
      add_en[p][phase_energy_pkg::SLOT_REACT_NEG] =
        cycle_end & ~low_power & react[EW-1];
      // Negating the most negative value gives 2^31, which fits unsigned
      addend[p][phase_energy_pkg::SLOT_REACT_NEG] = EW'(-react);
    end

    // Apparent total counts energy normally and current in low power
    always_comb begin
      add_en[p][phase_energy_pkg::SLOT_APPARENT] = cycle_end;
      if (low_power) begin
        addend[p][phase_energy_pkg::SLOT_APPARENT] = phase_in[p].current_last_cycle;
      end else begin
        addend[p][phase_energy_pkg::SLOT_APPARENT] = phase_in[p].fund_apparent_last_cycle;
      end
    end

    // Real result is routed one cycle after its copy, once it is stable
    always_comb begin
      add_en[p][phase_energy_pkg::SLOT_REAL_POS] =
        real_done[p] & ~low_power & (real_cycle[p] > 0);
      addend[p][phase_energy_pkg::SLOT_REAL_POS] = real_cycle[p];
      add_en[p][phase_energy_pkg::SLOT_REAL_NEG] =
        real_done[p] & ~low_power & real_cycle[p][EW-1];
      addend[p][phase_energy_pkg::SLOT_REAL_NEG] = EW'(-real_cycle[p]);
    end

    for (genvar s = 0; s < NS; s++) begin : g_slot
      energy_accum #(
        .WIDTH(EW)
      ) u_acc (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .add_en(add_en[p][s]),
        .addend(addend[p][s]),
        .total(total[p][s]),
        .wrap_pulse(wrap[p][s])
      );
    end

    // Wraps of the fundamental totals map onto the flag byte
    always_comb begin
      flag_set = '0;
      flag_set[phase_energy_pkg::FLAG_REACT_POS_BIT] =
        wrap[p][phase_energy_pkg::SLOT_REACT_POS];
      flag_set[phase_energy_pkg::FLAG_REACT_NEG_BIT] =
        wrap[p][phase_energy_pkg::SLOT_REACT_NEG];
      flag_set[phase_energy_pkg::FLAG_APPARENT_BIT] =
        wrap[p][phase_energy_pkg::SLOT_APPARENT];
    end

    // Host clears by writing ones to the flag byte
    assign flag_clr = (reg_req.wr && reg_req.addr == phase_energy_pkg::ADDR_FLAGS[p]) ?
                      reg_req.wdata : '0;

    // Sticky flags; a wrap in the clearing cycle survives the clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        flags_reg[p] <= phase_energy_pkg::FLAG_RESET;
      end else begin
        flags_reg[p] <= (flags_reg[p] & ~flag_clr) | flag_set;
      end
    end
  end

  // Read decode; every total but the low-power apparent count keeps the same LSB weight, so no scaling here
  always_comb begin
    rdata_next = '0;
    for (int p = 0; p < NP; p++) begin
      if (reg_req.addr == phase_energy_pkg::ADDR_REAL_CYCLE[p]) begin
        rdata_next = real_cycle[p];
      end else if (reg_req.addr == phase_energy_pkg::ADDR_REACT_POS[p]) begin
        rdata_next = total[p][phase_energy_pkg::SLOT_REACT_POS];
      end else if (reg_req.addr == phase_energy_pkg::ADDR_REACT_NEG[p]) begin
        rdata_next = total[p][phase_energy_pkg::SLOT_REACT_NEG];
      end else if (reg_req.addr == phase_energy_pkg::ADDR_APPARENT[p]) begin
        rdata_next = total[p][phase_energy_pkg::SLOT_APPARENT];
      end else if (reg_req.addr == phase_energy_pkg::ADDR_REAL_POS[p]) begin
        rdata_next = total[p][phase_energy_pkg::SLOT_REAL_POS];
      end else if (reg_req.addr == phase_energy_pkg::ADDR_REAL_NEG[p]) begin
        rdata_next = total[p][phase_energy_pkg::SLOT_REAL_NEG];
      end else if (reg_req.addr == phase_energy_pkg::ADDR_FLAGS[p]) begin
        rdata_next = {{(EW-FW){1'b0}}, flags_reg[p]}; // Reserved bits read zero
      end
    end
  end

  // Read data is registered so outputs come straight from flops; unmapped reads give zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= phase_energy_pkg::ENERGY_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

endmodule
`default_nettype wire

// >>> dv/phase_energy_monitor.sv
// Port-level assertions for the phase energy accumulators
`timescale 1ns/1ns
`default_nettype none
module phase_energy_monitor (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sample_en,
  input wire logic cycle_end,
  input wire logic low_power,
  input wire phase_energy_pkg::phase_in_s phase_in [phase_energy_pkg::NUM_PHASES],
  input wire phase_energy_pkg::reg_req_s reg_req,
  input wire logic [phase_energy_pkg::ENERGY_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Read of one address, without a cycle boundary at that edge, or in low power
  sequence s_rd(a);
    reg_req.rd && reg_req.addr == a && !cycle_end;
  endsequence
  sequence s_rd_lp(a);
    reg_req.rd && reg_req.addr == a && low_power;
  endsequence
  a_read_answer_once: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  a_no_stray_answer: assert property (!reg_req.rd |=> !reg_rvalid)
    else $error("answer without a read");
  a_rdata_holds_idle: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_reads_zero: assert property (reg_req.rd && reg_req.addr == 12'h000 |=>
    reg_rdata == 32'h0) else $error("unmapped read not zero");
  a_reset_read_clear: assert property ($rose(rst_b) |-> reg_rdata == 32'h0 && !reg_rvalid)
    else $error("read port not clear after reset");
  a_flag_spare_zero: assert property (
    reg_req.rd && reg_req.addr == phase_energy_pkg::ADDR_FLAGS[0] |=>
    reg_rdata[31:5] == 27'h0 && reg_rdata[1:0] == 2'h0) else $error("spare flag bits set");
  a_total_holds_idle: assert property (
    s_rd(phase_energy_pkg::ADDR_REACT_POS[0]) ##1 !cycle_end ##1
    s_rd(phase_energy_pkg::ADDR_REACT_POS[0]) |=> reg_rdata == $past(reg_rdata, 2))
    else $error("total moved without cycle end");
  a_low_power_frozen: assert property (
    s_rd_lp(phase_energy_pkg::ADDR_REACT_NEG[1]) ##1 (cycle_end && !reg_req.rd) ##1
    s_rd_lp(phase_energy_pkg::ADDR_REACT_NEG[1]) |=> reg_rdata == $past(reg_rdata, 2))
    else $error("reactive total moved in low power");
endmodule
bind phase_energy_accumulators phase_energy_monitor phase_energy_monitor_i (
  .clk_sys(clk_sys), .rst_b(rst_b), .sample_en(sample_en), .cycle_end(cycle_end),
  .low_power(low_power), .phase_in(phase_in), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid));
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the phase energy accumulators
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic sample_en = 1'b0;
  logic cycle_end = 1'b0;
  logic low_power = 1'b0;
  phase_energy_pkg::phase_in_s phase_in [phase_energy_pkg::NUM_PHASES];
  phase_energy_pkg::reg_req_s reg_req = '0;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic [31:0] e [3][7];
  logic [31:0] sm [3];
  int n_errors = 0;
  int check_count = 0;
  // Clock at 25 MHz
  always #20 clk_sys = ~clk_sys;
  phase_energy_accumulators phase_energy_accumulators_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .sample_en(sample_en), .cycle_end(cycle_end), .low_power(low_power), .phase_in(phase_in),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Entered just after a falling edge; answer is looked at in its one valid cycle
  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    @(negedge clk_sys);
    reg_req.rd = 1'b0;
    cmp($sformatf("rvalid %h", a), 32'h1, {31'h0, reg_rvalid});
    cmp($sformatf("rdata %h", a), ex, reg_rdata);
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(negedge clk_sys);
    reg_req.wr = 1'b0;
    @(negedge clk_sys);
  endtask
  function automatic logic [11:0] addr(input int p, input int k);
    case (k)
      0: return phase_energy_pkg::ADDR_REACT_POS[p];
      1: return phase_energy_pkg::ADDR_REACT_NEG[p];
      2: return phase_energy_pkg::ADDR_APPARENT[p];
      3: return phase_energy_pkg::ADDR_REAL_CYCLE[p];
      4: return phase_energy_pkg::ADDR_REAL_POS[p];
      5: return phase_energy_pkg::ADDR_REAL_NEG[p];
      default: return phase_energy_pkg::ADDR_FLAGS[p];
    endcase
  endfunction
  task automatic chk();
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 7; k++) begin
        rd(addr(p, k), e[p][k]);
      end
    end
  endtask
  // Wrapping add into the expected total; carry out sets the flag bit when one exists
  task automatic acc(input int p, input int k, input logic [31:0] v, input int b);
    logic [32:0] t;
    t = {1'b0, e[p][k]} + {1'b0, v};
    e[p][k] = t[31:0];
    if (t[32] && b >= 0) begin
      e[p][6][b] = 1'b1;
    end
  endtask
  task automatic model();
    logic signed [31:0] r;
    for (int p = 0; p < 3; p++) begin
      r = phase_in[p].fund_reactive_last_cycle;
      e[p][3] = sm[p];
      if (!low_power) begin
        if (r > 0) acc(p, 0, r, 2);
        if (r < 0) acc(p, 1, -r, 3);
        acc(p, 2, phase_in[p].fund_apparent_last_cycle, 4);
        if ($signed(sm[p]) > 0) acc(p, 4, sm[p], -1);
        if ($signed(sm[p]) < 0) acc(p, 5, -sm[p], -1);
      end else begin
        acc(p, 2, phase_in[p].current_last_cycle, 4);
      end
      sm[p] = 32'h0;
    end
  endtask
  // One sample strobe; currents differ per phase so real sums take both signs
  task automatic samp(input logic signed [15:0] v);
    for (int p = 0; p < 3; p++) begin
      phase_in[p].inst_voltage = v;
      phase_in[p].inst_current = 16'(3 - 2 * p);
      sm[p] = sm[p] + 32'(int'(v) * (3 - 2 * p));
    end
    sample_en = 1'b1;
    @(negedge clk_sys);
    sample_en = 1'b0;
    @(negedge clk_sys);
  endtask
  // Cycle end bracketed by two reads of one total, to catch early or missed updates
  task automatic ce(input logic [31:0] r, input logic [31:0] s);
    fork
      rd(phase_energy_pkg::ADDR_REACT_NEG[1], e[1][1]);
      begin
        for (int p = 0; p < 3; p++) begin
          phase_in[p].fund_reactive_last_cycle = (p == 0) ? r : ((p == 1) ? -r : 32'h0);
          phase_in[p].fund_apparent_last_cycle = s + 32'(p);
          phase_in[p].current_last_cycle = 32'(p + 7);
        end
        @(negedge clk_sys);
        cycle_end = 1'b1;
        model();
        @(negedge clk_sys);
        cycle_end = 1'b0;
      end
    join
    rd(phase_energy_pkg::ADDR_REACT_NEG[1], e[1][1]);
  endtask
  // Expected state after any reset: every total, flag and running sum at zero
  task automatic zero_model();
    for (int p = 0; p < 3; p++) begin
      sm[p] = 32'h0;
      for (int k = 0; k < 7; k++) e[p][k] = 32'h0;
    end
  endtask
  // Wrap lands on the edge that takes a clear of that flag; a sample rides on the boundary
  task automatic ce_clr(input logic [31:0] s);
    for (int p = 0; p < 3; p++) begin
      phase_in[p].fund_reactive_last_cycle = 32'h0;
      phase_in[p].fund_apparent_last_cycle = s;
      sm[p] = sm[p] + 32'(int'(phase_in[p].inst_voltage) * int'(phase_in[p].inst_current));
    end
    sample_en = 1'b1;
    cycle_end = 1'b1;
    model();
    @(negedge clk_sys);
    sample_en = 1'b0;
    cycle_end = 1'b0;
    reg_req.wr = 1'b1;
    reg_req.addr = phase_energy_pkg::ADDR_FLAGS[2];
    reg_req.wdata = 8'h10;
    @(negedge clk_sys);
    reg_req.wr = 1'b0;
    @(negedge clk_sys);
  endtask
  initial begin
    for (int p = 0; p < 3; p++) begin
      phase_in[p] = '0;
    end
    zero_model();
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    chk();
    samp(16'sh0100);
    samp(-16'sh0040);
    ce(32'h5, 32'h64);
    chk();
    repeat (2) ce(32'h7FFFFFFF, 32'hFFFFFFF0);
    ce(32'h1, 32'h1);
    chk();
    repeat (2) rd(phase_energy_pkg::ADDR_REACT_POS[0], e[0][0]);
    wr(phase_energy_pkg::ADDR_FLAGS[0], 8'h04);
    e[0][6][2] = 1'b0;
    wr(phase_energy_pkg::ADDR_FLAGS[1], 8'hFF);
    e[1][6] = 32'h0;
    wr(phase_energy_pkg::ADDR_REACT_POS[2], 8'hFF);
    chk();
    low_power = 1'b1;
    samp(16'sh0010);
    ce(32'h9, 32'h50);
    low_power = 1'b0;
    chk();
    ce_clr(32'hFFFFFFF0);
    chk();
    // Mid-run reset must clear totals, flags and the read port
    rst_b = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    zero_model();
    @(negedge clk_sys);
    chk();
    rd(12'h000, 32'h0);
    conclude();
  end
  // Hang guard
  initial begin
    #100000;
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire
